// File: verilog/dmsd_decode.sv
// Contract
// (RQ1) Direct accesses to 80h-FFh reach SFRs; indirect ones never do.
// (RQ2) 128 bytes of scratch-pad RAM are reachable directly and indirectly.
// (RQ3) Indirect 80h-FFh reaches upper RAM; direct 00h-7Fh reaches RAM.
// (RQ4) Four banks of eight 8-bit working registers, each one addressable.
// (RQ5) Bank n occupies RAM bytes n*8 to n*8+7, filling 00h-1Fh.
// (RQ6) One bank is active, picked by the two status-word bank-select bits.
// (RQ7) Working registers zero and one of the bank act as indirect pointers.
// (RQ8) RAM bytes 20h-2Fh allow both byte access and single-bit access.
// (RQ9) Bit address b below 80h maps to RAM byte 20h+b/8, bit b mod 8.
// (RQ10) Bit or byte access is decided from the instruction type alone.
// (RQ11) Only implemented SFRs at addresses ending in 0 or 8 take bit access.
// (RQ12) Calls, interrupts and saving jumps put the return address on stack.
// (RQ13) The stack pointer resets to 07h and may be rewritten freely later.
// (RQ14) The stack may begin anywhere in RAM, with no limit on the pointer.
// (RQ15) A push increments the pointer first, then writes at the new address.
// (RQ16) A pop reads at the current pointer first, then decrements it.
// (RQ17) Unoccupied SFR addresses and unimplemented bits read as ones; the code stores all eight bits of every implemented SFR.
`timescale 1ns/1ps
`default_nettype none
module dmsd_decode
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Access request from the execution core
    input  wire dmsd_pkg::dmsd_req_t req,
    // Registered answer
    output var  dmsd_pkg::dmsd_rsp_t rsp_r,
    // Visible core state
    output var  logic [7:0]        stack_pointer,
    output var  logic [7:0]        program_status_word
);

    logic [7:0] ram_q [dmsd_pkg::RAM_BYTES];
    logic [7:0] sfr_q [dmsd_pkg::SFR_COUNT];

    logic [1:0] bank;
    logic [7:0] ptr_val;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic       tgt_sfr;
    logic       is_bit;
    logic       sfr_impl;
    logic [7:0] rd_byte;
    logic [7:0] new_byte;
    logic       ram_we;
    logic       sfr_we;
    logic       stk_upd;
    logic [7:0] stk_nxt;
    logic [7:0] stk_top;

    assign stack_pointer       = sfr_q[dmsd_pkg::SP_IDX];
    assign program_status_word = sfr_q[dmsd_pkg::PSW_IDX];

    // Bank choice is live: a status-word write affects the next access
    assign bank = {program_status_word[dmsd_pkg::BANK_HI_POS],
                   program_status_word[dmsd_pkg::BANK_LO_POS]}; // [RQ6]

    // Pointer register sits at offset 0 or 1 inside the active bank
    assign ptr_val = ram_q[{3'b000, bank, 2'b00, req.addr[0]}]; // [RQ7]
    assign stk_top = ram_q[stack_pointer];

    always_comb
    begin
        byte_addr = req.addr;
        bit_pos   = 3'h0;
        tgt_sfr   = 1'b0;
        is_bit    = 1'b0;
        case (req.op)
            dmsd_pkg::DMSD_OP_DIRECT:
            begin
                byte_addr = req.addr;
                tgt_sfr   = req.addr[7]; // [RQ1] [RQ3]
            end
            dmsd_pkg::DMSD_OP_INDIRECT:
            begin
                byte_addr = req.addr; // [RQ1] [RQ2] [RQ3]
            end
            dmsd_pkg::DMSD_OP_WREG:
            begin
                byte_addr = {3'b000, bank, req.addr[2:0]}; // [RQ4] [RQ5]
            end
            dmsd_pkg::DMSD_OP_POINTER:
            begin
                byte_addr = ptr_val; // [RQ7]
            end
            dmsd_pkg::DMSD_OP_BIT:
            begin
                // Kind of access comes from the op code only
                is_bit  = 1'b1; // [RQ10]
                bit_pos = req.addr[2:0];
                if (req.addr[7])
                begin
                    // Only column 0/8 bytes are reachable this way
                    byte_addr = {req.addr[7:3], 3'b000}; // [RQ11]
                    tgt_sfr   = 1'b1;
                end
                else
                begin
                    byte_addr = dmsd_pkg::BIT_RAM_BASE
                              + {4'h0, req.addr[6:3]}; // [RQ8] [RQ9]
                end
            end
            dmsd_pkg::DMSD_OP_PUSH:
            begin
                // Wraps through FFh to 00h; no range limit on the stack
                byte_addr = stack_pointer + dmsd_pkg::STEP_ONE; // [RQ14] [RQ15]
            end
            dmsd_pkg::DMSD_OP_POP:
            begin
                byte_addr = stack_pointer; // [RQ16]
            end
            default:
            begin
                byte_addr = req.addr;
            end
        endcase
    end

    assign sfr_impl = dmsd_pkg::SFR_IMPL_MASK[byte_addr[6:0]];
    // Unoccupied SFR slots are not flops; they read as all ones
    assign rd_byte  = tgt_sfr ? sfr_q[byte_addr[6:0]]
                              : ram_q[byte_addr]; // [RQ17]

    always_comb
    begin
        new_byte = req.wdata;
        if (is_bit)
        begin
            // Read-modify-write keeps the other seven bits intact
            new_byte          = rd_byte;
            new_byte[bit_pos] = req.wdata[0]; // [RQ8] [RQ9]
        end
    end

    assign stk_upd = req.valid
                   && (req.op == dmsd_pkg::DMSD_OP_PUSH
                       || req.op == dmsd_pkg::DMSD_OP_POP);
    assign stk_nxt = (req.op == dmsd_pkg::DMSD_OP_PUSH)
                   ? stack_pointer + dmsd_pkg::STEP_ONE  // [RQ15]
                   : stack_pointer - dmsd_pkg::STEP_ONE; // [RQ16]

    // A push always writes: it carries a return-address byte
    assign ram_we = req.valid && !tgt_sfr
                  && ((req.write && req.op != dmsd_pkg::DMSD_OP_POP)
                      || req.op == dmsd_pkg::DMSD_OP_PUSH); // [RQ12] [RQ15]
    // Writes to holes are dropped so they keep reading as ones
    assign sfr_we = req.valid && tgt_sfr && req.write && sfr_impl; // [RQ11]

    // Scratch-pad RAM: contents are not cleared by reset
    always_ff @(posedge clk)
    begin
        if (ram_we)
        begin
            ram_q[byte_addr] <= new_byte; // [RQ2]
        end
    end

    // SFR storage exists only at occupied addresses
    genvar gi;
    generate
        for (gi = 0; gi < dmsd_pkg::SFR_COUNT; gi++)
        begin : g_sfr
            if (dmsd_pkg::SFR_IMPL_MASK[gi])
            begin : g_impl
                localparam logic [7:0] RV = (gi == dmsd_pkg::SP_IDX)
                                          ? dmsd_pkg::SP_RST
                                          : dmsd_pkg::SFR_RST;
                // Each slot owns its flop; the array is only a read view
                logic [7:0] val_r;
                always_ff @(posedge clk or negedge rst_b)
                begin
                    if (!rst_b)
                    begin
                        val_r <= RV; // [RQ13]
                    end
                    else if (gi == dmsd_pkg::SP_IDX && stk_upd)
                    begin
                        val_r <= stk_nxt; // [RQ15] [RQ16]
                    end
                    else if (sfr_we && byte_addr[6:0] == 7'(gi))
                    begin
                        val_r <= new_byte; // [RQ1] [RQ13]
                    end
                end
                assign sfr_q[gi] = val_r;
            end
            else
            begin : g_hole
                assign sfr_q[gi] = dmsd_pkg::UNIMPL_VAL; // [RQ17]
            end
        end
    endgenerate

    // Answer: one cycle after each request, old contents of the target
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r.valid <= req.valid;
            rsp_r.rdata <= rd_byte; // [RQ16] [RQ17]
            rsp_r.rbit  <= rd_byte[bit_pos]; // [RQ9]
        end
    end

    // Helper state for the checks below
    logic init_seen_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            init_seen_r <= 1'b0;
        end
        else if (req.valid)
        begin
            init_seen_r <= 1'b1;
        end
    end

    // Home byte of a RAM bit, formed apart from the decoder's own sum
    logic [7:0] bit_home_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_home_r <= 8'h00;
        end
        else
        begin
            bit_home_r <= {4'h2, req.addr[6:3]};
        end
    end
    logic [7:0] bit_home_q;
    assign bit_home_q = ram_q[bit_home_r];
    logic [7:0] last_addr_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_addr_r <= 8'h00;
        end
        else
        begin
            last_addr_r <= byte_addr;
        end
    end
    logic [7:0] last_ram_q;
    assign last_ram_q = ram_q[last_addr_r];
    // RAM byte named by the raw address, whatever the access kind
    logic [7:0] ind_src;
    assign ind_src = ram_q[req.addr];

    property p_sfr_no_indirect;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.write && req.op == dmsd_pkg::DMSD_OP_INDIRECT
         && req.addr == 8'h81)
        |=> stack_pointer == $past(stack_pointer);
    endproperty
    a_sfr_no_indirect: assert property (p_sfr_no_indirect) // [RQ1]
        else $error("indirect write reached an SFR");

    property p_ram_write;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.write
         && (req.op == dmsd_pkg::DMSD_OP_INDIRECT
             || (req.op == dmsd_pkg::DMSD_OP_DIRECT && !req.addr[7])))
        |=> last_ram_q == $past(req.wdata);
    endproperty
    a_ram_write: assert property (p_ram_write) // [RQ2]
        else $error("RAM byte write did not land");

    property p_wreg_bank;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.op == dmsd_pkg::DMSD_OP_WREG)
        |-> byte_addr == {3'b000, program_status_word[4:3], req.addr[2:0]};
    endproperty
    a_wreg_bank: assert property (p_wreg_bank) // [RQ5]
        else $error("working register mapped to wrong bank");

    property p_sp_reset;
        @(posedge clk) disable iff (!rst_b)
        !init_seen_r |-> stack_pointer == dmsd_pkg::SP_RST;
    endproperty
    a_sp_reset: assert property (p_sp_reset) // [RQ13]
        else $error("stack pointer not 07h after reset");

    property p_push;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.op == dmsd_pkg::DMSD_OP_PUSH)
        |=> stack_pointer == 8'($past(stack_pointer) + 8'h01)
            && stk_top == $past(req.wdata);
    endproperty
    a_push: assert property (p_push) // [RQ15]
        else $error("push order wrong");

    property p_pop;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.op == dmsd_pkg::DMSD_OP_POP)
        |=> rsp_r.valid && rsp_r.rdata == $past(stk_top)
            && stack_pointer == 8'($past(stack_pointer) - 8'h01);
    endproperty
    a_pop: assert property (p_pop) // [RQ16]
        else $error("pop order wrong");

    property p_unimpl_ones;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && tgt_sfr && !sfr_impl)
        |=> rsp_r.rdata == 8'hFF && rsp_r.rbit;
    endproperty
    a_unimpl_ones: assert property (p_unimpl_ones) // [RQ17]
        else $error("unoccupied SFR did not read ones");

    property p_bit_ram;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.write && req.op == dmsd_pkg::DMSD_OP_BIT
         && !req.addr[7])
        |=> bit_home_q[$past(req.addr[2:0])] == $past(req.wdata[0]);
    endproperty
    a_bit_ram: assert property (p_bit_ram) // [RQ9]
        else $error("bit write missed its RAM byte");

    property p_bit_sfr_col;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.op == dmsd_pkg::DMSD_OP_BIT && req.addr[7])
        |-> tgt_sfr && byte_addr[2:0] == 3'h0;
    endproperty
    a_bit_sfr_col: assert property (p_bit_sfr_col) // [RQ11]
        else $error("bit access left the 0/8 column");

    property p_bit_psw;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && req.write && req.op == dmsd_pkg::DMSD_OP_BIT
         && req.addr[7:3] == 5'h1A)
        |=> program_status_word[$past(req.addr[2:0])] == $past(req.wdata[0]);
    endproperty
    a_bit_psw: assert property (p_bit_psw) // [RQ11]
        else $error("bit write missed the status word");

    property p_indirect_ram;
        @(posedge clk) disable iff (!rst_b)
        (req.valid && !req.write && req.addr[7]
         && req.op == dmsd_pkg::DMSD_OP_INDIRECT)
        |=> rsp_r.rdata == $past(ind_src);
    endproperty
    a_indirect_ram: assert property (p_indirect_ram) // [RQ3]
        else $error("indirect read above 7Fh missed upper RAM");

endmodule
`default_nettype wire

// File: verilog/dmsd_pkg.sv
`default_nettype none
package dmsd_pkg;

    // Kind of data-space access, chosen by the instruction decoder
    typedef enum logic [2:0]
    {
        DMSD_OP_DIRECT,
        DMSD_OP_INDIRECT,
        DMSD_OP_WREG,
        DMSD_OP_POINTER,
        DMSD_OP_BIT,
        DMSD_OP_PUSH,
        DMSD_OP_POP
    } dmsd_op_t;

    typedef struct packed
    {
        logic       valid;
        dmsd_op_t   op;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmsd_req_t;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] rdata;
        logic       rbit;
    } dmsd_rsp_t;

    localparam int unsigned RAM_BYTES      = 256;
    localparam int unsigned SFR_COUNT      = 128;
    localparam logic [6:0]  SP_IDX         = 7'h01;
    localparam logic [6:0]  PSW_IDX        = 7'h50;
    localparam int unsigned BANK_HI_POS    = 4;
    localparam int unsigned BANK_LO_POS    = 3;
    localparam logic [7:0]  SP_RST         = 8'h07;
    localparam logic [7:0]  SFR_RST        = 8'h00;
    localparam logic [7:0]  UNIMPL_VAL     = 8'hFF;
    localparam logic [7:0]  BIT_RAM_BASE   = 8'h20;
    localparam logic [7:0]  STEP_ONE       = 8'h01;
    // Bit i set when SFR address 80h+i holds a register
    localparam logic [127:0] SFR_IMPL_MASK =
        128'h01_C1_01_01_FF_EF_C0_C3_F3_FE_33_07_03_21_7F_8F;

endpackage
`default_nettype wire

// File: dv/dmsd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmsd_core_model
(
    // Clock
    input  wire logic                clk,
    // Request to the decoder and its answer
    output var  dmsd_pkg::dmsd_req_t req,
    input  wire dmsd_pkg::dmsd_rsp_t rsp_r
);
    dmsd_pkg::dmsd_rsp_t got;

    initial
    begin
        req = '0;
        got = '0;
    end

    // Write flag, address and data are inverted and valid drops once released, so a stale request never repeats
    task automatic access(input logic [2:0] op, input logic wr,
                          input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        req <= '{1'b1, dmsd_pkg::dmsd_op_t'(op), wr, addr, wdata};
        @(posedge clk);
        req <= '{1'b0, dmsd_pkg::dmsd_op_t'(op), ~wr, ~addr, ~wdata};
        #1;
        got = rsp_r;
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                clk;
    logic                rst_b;
    dmsd_pkg::dmsd_req_t req;
    dmsd_pkg::dmsd_rsp_t rsp_r;
    logic [7:0]          stack_pointer;
    logic [7:0]          program_status_word;
    int                  err_count;
    int                  check_count;
    int                  ram [256];
    int                  sfr [128];
    bit                  fill;
    int                  seed;

    dmsd_decode DUT (.clk(clk), .rst_b(rst_b), .req(req), .rsp_r(rsp_r),
        .stack_pointer(stack_pointer),
        .program_status_word(program_status_word));
    dmsd_core_model cpu (.clk(clk), .req(req), .rsp_r(rsp_r));

    task automatic summarize();
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input int exp, input string m);
        check_count++;
        if (got !== exp[7:0])
        begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp[7:0]);
        end
    endtask

    task automatic chk1(input logic got, input int exp, input string m);
        check_count++;
        if (got !== exp[0])
        begin
            err_count++;
            $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp[0]);
        end
    endtask

    function automatic int rnd(input int n);
        return $urandom_range(0, n);
    endfunction

    function automatic bit impl(input int t);
        return dmsd_pkg::SFR_IMPL_MASK[t - 128];
    endfunction

    task automatic model_reset();
        foreach (sfr[i])
            sfr[i] = 0;
        sfr[1] = 7;
    endtask

    // Reference: old byte is answered, then the access takes effect
    task automatic do_op(input int op, input int w, input int a, input int d);
        int t;
        int b;
        int bank;
        int old;
        int nv;
        bit s;
        bank = (sfr[80] >> 3) & 3;
        b = (op == 4) ? a & 7 : 0;
        s = (op == 0 || op == 4) && a >= 128;
        if (op == 5)
            sfr[1] = (sfr[1] + 1) & 255;
        case (op)
            0, 1: t = a;
            2: t = bank * 8 + (a & 7);
            3: t = ram[bank * 8 + (a & 1)];
            4: t = (a < 128) ? 32 + a / 8 : a & 248;
            default: t = sfr[1];
        endcase
        old = !s ? ram[t] : impl(t) ? sfr[t - 128] : 255;
        nv = (op == 4) ? (old & ~(1 << b)) | ((d & 1) << b) : d;
        cpu.access(op[2:0], w[0], a[7:0], d[7:0]);
        if ((w == 1 && op != 6) || op == 5)
        begin
            if (!s)
                ram[t] = nv;
            else if (impl(t))
                sfr[t - 128] = nv;
        end
        if (op == 6)
            sfr[1] = (sfr[1] - 1) & 255;
        chk1(cpu.got.valid, 1, "valid");
        if (!fill)
        begin
            chk8(cpu.got.rdata, old, "rdata");
            chk1(cpu.got.rbit, (old >> b) & 1, "rbit");
        end
        chk8(stack_pointer, sfr[1], "sp");
        chk8(program_status_word, sfr[80], "psw");
    endtask

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        summarize();
    end

    initial
    begin
        rst_b = 0;
        err_count = 0;
        check_count = 0;
        fill = 1;
        model_reset();
        seed = $urandom(45);
        repeat (12) @(posedge clk);
        rst_b <= 1;
        // Scratch RAM powers up unknown, so it is filled before comparing
        for (int i = 0; i < 256; i++)
            do_op(1, 1, i, rnd(255));
        fill = 0;
        for (int i = 0; i < 256; i++)
            do_op(i < 128 ? 0 : 1, 0, i, 0);
        for (int i = 128; i < 256; i++)
            do_op(0, 0, i, 0);
        for (int i = 128; i < 256; i++)
            do_op(0, 1, i, rnd(255));
        for (int i = 128; i < 256; i++)
        begin
            do_op(0, 0, i, 0);
            do_op(1, 0, i, 0);
        end
        for (int k = 0; k < 4; k++)
        begin
            do_op(0, 1, 208, k * 8);
            for (int r = 0; r < 8; r++)
                do_op(2, r % 2, r, rnd(255));
            do_op(3, 0, 0, 0);
            do_op(3, 1, 1, rnd(255));
        end
        for (int i = 0; i < 256; i++)
            do_op(4, 1, i, rnd(1));
        do_op(0, 1, 129, 253);
        for (int i = 0; i < 4; i++)
            do_op(5, 1, 0, rnd(255));
        for (int i = 0; i < 5; i++)
            do_op(6, 0, 0, 0);
        for (int i = 0; i < 3000; i++)
            do_op(rnd(6), rnd(1), rnd(255), rnd(255));
        @(posedge clk);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        #1;
        model_reset();
        chk8(stack_pointer, 7, "sp reset");
        chk8(program_status_word, 0, "psw reset");
        chk1(rsp_r.valid, 0, "valid in reset");
        @(posedge clk);
        rst_b <= 1;
        do_op(0, 0, 129, 0);
        do_op(0, 0, 208, 0);
        summarize();
    end
endmodule
`default_nettype wire
